// File: standby_regs.svh
`ifndef STANDBY_REGS_SVH
`define STANDBY_REGS_SVH

`define CLK_PERIOD_NS        50
// stop-to-snooze: longest wait per oscillator frequency select, rounded down
`define STOP_SNOOZE_F0_NS    65000
`define STOP_SNOOZE_F1_NS    135000
`define STOP_SNOOZE_F0_CYC   (`STOP_SNOOZE_F0_NS / `CLK_PERIOD_NS)
`define STOP_SNOOZE_F1_CYC   (`STOP_SNOOZE_F1_NS / `CLK_PERIOD_NS)
// snooze-to-normal: least time per speed mode, rounded up
`define SNOOZE_NORM_HS_NS    4990
`define SNOOZE_NORM_LS_NS    1100
`define SNOOZE_NORM_HS_CYC   ((`SNOOZE_NORM_HS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SNOOZE_NORM_LS_CYC   ((`SNOOZE_NORM_LS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXTRA_VECTORED_CYC   7
`define EXTRA_PLAIN_CYC      1
`define RESET_VECTOR_ADDR    16'h0000

// controller register byte offsets
`define REG_CTRL             5'h00
`define REG_CONFIG           5'h04
`define REG_STATUS           5'h08
`define REG_IRQ_STAT         5'h0C
`define REG_IRQ_MASK         5'h10

// control register fields
`define CTRL_STOP_BIT        0
`define CTRL_SERIAL_SNZ_BIT  1
`define CTRL_ADC_SNZ_BIT     2
`define CTRL_VECTOR_BIT      3
`define CTRL_TIMERS_OFF_BIT  4
`define CTRL_CMP_FILTER_BIT  5
`define CTRL_RESET           8'h00

// config register fields
`define CFG_FREQ_SEL_BIT     0
`define CFG_WUT_CLK_BIT      1
`define CFG_HS_MODE_BIT      2
`define CFG_WDT_ON_BIT       3
`define CFG_WDT_STBY_BIT     4
`define CFG_CPU_FAST_OSC_BIT 5
`define CFG_RESET            8'h24

// event bits of the status and mask registers
`define EV_WOKE_BIT          0
`define EV_FALLBACK_BIT      1
`define EV_RESET_BIT         2
`define EV_REFUSED_BIT       3
`define EV_WIDTH             4

`endif

// File: standby_pkg.sv
package standby_pkg;
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_STOP,
    MODE_TO_SNOOZE,
    MODE_SNOOZE,
    MODE_TO_NORMAL,
    MODE_RESET
  } mode_t;
endpackage

// File: standby_if.sv
`timescale 1ns/1ns
interface standby_if;
  import standby_pkg::*;
  logic  stop_req;
  logic  serial_snooze_enable;
  logic  adc_snooze_enable;
  logic  oscillator_frequency_select;
  logic  wakeup_timer_clock_select;
  logic  speed_mode_control;
  logic  watchdog_enable_option;
  logic  watchdog_standby_run_option;
  logic  cpu_on_fast_osc;
  logic  vector_enable;
  logic  timers_stopped;
  logic  cmp_filter_used;
  mode_t mode;
  logic  woke;
  logic  fell_back;
  logic  reset_done;

  modport dev (
    input  stop_req, serial_snooze_enable, adc_snooze_enable, oscillator_frequency_select,
           wakeup_timer_clock_select, speed_mode_control, watchdog_enable_option,
           watchdog_standby_run_option, cpu_on_fast_osc, vector_enable, timers_stopped,
           cmp_filter_used,
    output mode, woke, fell_back, reset_done
  );
  modport ctl (
    output stop_req, serial_snooze_enable, adc_snooze_enable, oscillator_frequency_select,
           wakeup_timer_clock_select, speed_mode_control, watchdog_enable_option,
           watchdog_standby_run_option, cpu_on_fast_osc, vector_enable, timers_stopped,
           cmp_filter_used,
    input  mode, woke, fell_back, reset_done
  );
endinterface

// File: wait_timer.sv
`timescale 1ns/1ns
module wait_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        load_i,
  input  wire logic [11:0] count_i,
  output logic             done_o
);
  logic [11:0] cnt_ff;
  logic        busy_ff;

  // done pulses in the cycle the last count is consumed
  assign done_o = busy_ff && (cnt_ff == 12'h001);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 12'h000;
      busy_ff <= 1'b0;
    end else if (ce_i) begin
      if (load_i) begin
        cnt_ff  <= count_i;
        busy_ff <= (count_i != 12'h000);
      end else if (busy_ff) begin
        cnt_ff  <= cnt_ff - 12'h001;
        busy_ff <= (cnt_ff != 12'h001);
      end
    end
  end
endmodule

// File: standby_device.sv
// Behaviour
// - reset in stop leaves standby, reset sequence
// - after reset, fetch from vector address zero
// - only serial channels and converter start snooze
// - snooze enabled only on fast internal clock
// - serial snooze enable set just before stop
// - converter snooze enable set just before stop
// - stop-to-snooze wait per frequency select
// - snooze-to-normal with vectoring: time plus seven
// - snooze-to-normal without vectoring: time plus one
// - snooze gates cpu, runs internal oscillator only
// - slow oscillator by wake clock or watchdog
// - snooze stops cpu and ram, ports hold
// - other serial channels held disabled in snooze
// - comparator needs unused filter; others stay operable
// - event linker keeps linking in snooze
// - crc, guards, parity stopped through stop
// - software stops timers and buzzer before stop
// - software clears snooze enable after wake
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "standby_regs.svh"
module standby_device (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  standby_if.dev                  link,
  input  wire logic               reset_source_i,
  input  wire logic               serial_activity_i,
  input  wire logic               adc_trigger_i,
  input  wire logic               serial_irq_i,
  input  wire logic               adc_irq_i,
  input  wire logic               periph_idle_i,
  output logic                    cpu_clk_en_o,
  output logic                    cpu_ram_run_o,
  output logic                    fast_osc_run_o,
  output logic                    crystal_run_o,
  output logic                    ext_clk_accept_o,
  output logic                    slow_osc_run_o,
  output logic                    port_hold_o,
  output logic                    serial_snz_ch_en_o,
  output logic                    serial_other_en_o,
  output logic                    adc_en_o,
  output logic                    cmp_en_o,
  output logic                    aux_periph_en_o,
  output logic                    event_linker_en_o,
  output logic                    safety_run_o,
  output logic                    fetch_o,
  output logic [15:0]             fetch_addr_o,
  output standby_pkg::mode_t      mode_o
);
  import standby_pkg::*;

  mode_t       state_ff;
  mode_t       nxt_state;
  logic        serial_arm_ff;
  logic        adc_arm_ff;
  logic        woke_ff;
  logic        fell_back_ff;
  logic        reset_done_ff;
  logic        fetch_ff;
  logic        safety_run_ff;
  logic        load;
  logic [11:0] load_count;
  logic        timer_done;
  logic        wake_req;
  logic        snz_start;

  function automatic logic [11:0] stop_snooze_cycles(input logic freq_sel);
    stop_snooze_cycles = freq_sel ? 12'(`STOP_SNOOZE_F1_CYC) : 12'(`STOP_SNOOZE_F0_CYC);
  endfunction

  function automatic logic [11:0] snooze_normal_cycles(input logic hs, input logic vect);
    logic [11:0] base;
    logic [11:0] extra;
    base  = hs ? 12'(`SNOOZE_NORM_HS_CYC) : 12'(`SNOOZE_NORM_LS_CYC);
    extra = vect ? 12'(`EXTRA_VECTORED_CYC) : 12'(`EXTRA_PLAIN_CYC);
    snooze_normal_cycles = base + extra;
  endfunction

  wait_timer u_wait_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .load_i  (load),
    .count_i (load_count),
    .done_o  (timer_done)
  );

  // only the armed serial channel or converter may start a snooze or wake from it
  assign snz_start = (serial_arm_ff && serial_activity_i) || (adc_arm_ff && adc_trigger_i);
  assign wake_req  = (serial_arm_ff && serial_irq_i) || (adc_arm_ff && adc_irq_i);

  always_comb begin
    nxt_state  = state_ff;
    load       = 1'b0;
    load_count = 12'h000;
    if (reset_source_i) begin
      nxt_state = MODE_RESET;
    end else begin
      case (state_ff)
        MODE_RUN: begin
          if (link.stop_req) begin
            nxt_state = MODE_STOP;
          end
        end
        MODE_STOP: begin
          if (snz_start) begin
            nxt_state  = MODE_TO_SNOOZE;
            load       = 1'b1;
            load_count = stop_snooze_cycles(link.oscillator_frequency_select);
          end
        end
        MODE_TO_SNOOZE: begin
          if (timer_done) begin
            nxt_state = MODE_SNOOZE;
          end
        end
        MODE_SNOOZE: begin
          if (wake_req) begin
            nxt_state  = MODE_TO_NORMAL;
            load       = 1'b1;
            load_count = snooze_normal_cycles(link.speed_mode_control, link.vector_enable);
          end else if (periph_idle_i) begin
            nxt_state = MODE_STOP;
          end
        end
        MODE_TO_NORMAL: begin
          if (timer_done) begin
            nxt_state = MODE_RUN;
          end
        end
        MODE_RESET: begin
          nxt_state = MODE_RUN;
        end
        default: begin
          nxt_state = MODE_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= MODE_RESET;
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // enables are sampled at stop entry; software writes them just before
  // stop and may clear them on wake without disturbing a snooze in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_arm_ff <= 1'b0;
      adc_arm_ff    <= 1'b0;
    end else if (ce_i) begin
      if (state_ff == MODE_RUN && link.stop_req) begin
        serial_arm_ff <= link.serial_snooze_enable && link.cpu_on_fast_osc;
        adc_arm_ff    <= link.adc_snooze_enable && link.cpu_on_fast_osc;
      end else if (nxt_state == MODE_RUN || nxt_state == MODE_RESET) begin
        serial_arm_ff <= 1'b0;
        adc_arm_ff    <= 1'b0;
      end
    end
  end

  // safety functions stop as stop is entered and restart only in run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      safety_run_ff <= 1'b1;
    end else if (ce_i) begin
      safety_run_ff <= (nxt_state == MODE_RUN);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      woke_ff       <= 1'b0;
      fell_back_ff  <= 1'b0;
      reset_done_ff <= 1'b0;
      fetch_ff      <= 1'b0;
    end else if (ce_i) begin
      woke_ff       <= (state_ff == MODE_TO_NORMAL) && (nxt_state == MODE_RUN);
      fell_back_ff  <= (state_ff == MODE_SNOOZE) && (nxt_state == MODE_STOP);
      reset_done_ff <= (state_ff == MODE_RESET) && (nxt_state == MODE_RUN);
      fetch_ff      <= (state_ff == MODE_RESET) && (nxt_state == MODE_RUN);
    end
  end

  assign fetch_o        = fetch_ff;
  assign fetch_addr_o   = `RESET_VECTOR_ADDR;
  assign mode_o         = state_ff;
  assign link.mode      = state_ff;
  assign link.woke      = woke_ff;
  assign link.fell_back = fell_back_ff;
  assign link.reset_done = reset_done_ff;
  assign safety_run_o   = safety_run_ff;

  // clock and peripheral gating per mode
  always_comb begin
    cpu_clk_en_o       = 1'b0;
    cpu_ram_run_o      = 1'b0;
    fast_osc_run_o     = 1'b0;
    crystal_run_o      = 1'b0;
    ext_clk_accept_o   = 1'b0;
    slow_osc_run_o     = 1'b0;
    port_hold_o        = 1'b0;
    serial_snz_ch_en_o = 1'b0;
    serial_other_en_o  = 1'b0;
    adc_en_o           = 1'b0;
    cmp_en_o           = 1'b0;
    aux_periph_en_o    = 1'b0;
    event_linker_en_o  = 1'b0;
    case (state_ff)
      MODE_RUN: begin
        cpu_clk_en_o      = 1'b1;
        cpu_ram_run_o     = 1'b1;
        fast_osc_run_o    = 1'b1;
        crystal_run_o     = 1'b1;
        ext_clk_accept_o  = 1'b1;
        slow_osc_run_o    = 1'b1;
        serial_snz_ch_en_o = 1'b1;
        serial_other_en_o = 1'b1;
        adc_en_o          = 1'b1;
        cmp_en_o          = 1'b1;
        aux_periph_en_o   = 1'b1;
        event_linker_en_o = 1'b1;
      end
      MODE_SNOOZE, MODE_TO_SNOOZE, MODE_TO_NORMAL, MODE_STOP: begin
        // cpu clock gated, crystal stopped, external clock ignored
        fast_osc_run_o     = (state_ff != MODE_STOP);
        port_hold_o        = 1'b1;
        // slow oscillator follows wake clock select, else watchdog options
        slow_osc_run_o     = link.wakeup_timer_clock_select ||
                             (link.watchdog_enable_option &&
                              link.watchdog_standby_run_option);
        serial_snz_ch_en_o = serial_arm_ff;
        serial_other_en_o  = 1'b0;
        adc_en_o           = adc_arm_ff || (state_ff != MODE_STOP);
        cmp_en_o           = !link.cmp_filter_used;
        aux_periph_en_o    = 1'b1;
        event_linker_en_o  = 1'b1;
      end
      default: begin
        cpu_clk_en_o = 1'b0;
      end
    endcase
  end
endmodule

// File: standby_controller.sv
`timescale 1ns/1ns
`include "standby_regs.svh"
module standby_controller (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  standby_if.ctl           link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o
);
  import standby_pkg::*;

  logic [7:0]             ctrl_ff;
  logic [7:0]             cfg_ff;
  logic [`EV_WIDTH-1:0]   stat_ff;
  logic [`EV_WIDTH-1:0]   mask_ff;
  logic                   ack_ff;
  logic [31:0]            rdata_ff;
  logic                   wr;
  logic                   stop_req_ff;
  logic                   refused;
  logic [`EV_WIDTH-1:0]   events;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && wb_sel_i[0];

  // snooze enables refused unless the cpu runs on the fast internal clock
  assign refused = wr && (wb_adr_i == `REG_CTRL) && !cfg_ff[`CFG_CPU_FAST_OSC_BIT] &&
                   (wb_dat_i[`CTRL_SERIAL_SNZ_BIT] || wb_dat_i[`CTRL_ADC_SNZ_BIT]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
      if (wb_adr_i == `REG_CTRL) begin
        rdata_ff <= {24'h000000, ctrl_ff};
      end else if (wb_adr_i == `REG_CONFIG) begin
        rdata_ff <= {24'h000000, cfg_ff};
      end else if (wb_adr_i == `REG_STATUS) begin
        rdata_ff <= {29'h0000_0000, link.mode};
      end else if (wb_adr_i == `REG_IRQ_STAT) begin
        rdata_ff <= {28'h000_0000, stat_ff};
      end else if (wb_adr_i == `REG_IRQ_MASK) begin
        rdata_ff <= {28'h000_0000, mask_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `CTRL_RESET;
      cfg_ff  <= `CFG_RESET;
    end else if (ce_i) begin
      if (wr && wb_adr_i == `REG_CONFIG) begin
        cfg_ff <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `REG_CTRL) begin
        ctrl_ff <= wb_dat_i[7:0];
        if (!cfg_ff[`CFG_CPU_FAST_OSC_BIT]) begin
          ctrl_ff[`CTRL_SERIAL_SNZ_BIT] <= 1'b0;
          ctrl_ff[`CTRL_ADC_SNZ_BIT]    <= 1'b0;
        end
        ctrl_ff[`CTRL_STOP_BIT] <= 1'b0;
      end else if (link.woke || link.reset_done) begin
        ctrl_ff[`CTRL_SERIAL_SNZ_BIT] <= 1'b0;
        ctrl_ff[`CTRL_ADC_SNZ_BIT]    <= 1'b0;
      end
    end
  end

  // stop is a one-cycle request, issued only once timers are stopped, and
  // in the same write that sets the snooze enables so they land just before
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_req_ff <= 1'b0;
    end else if (ce_i) begin
      stop_req_ff <= wr && (wb_adr_i == `REG_CTRL) && wb_dat_i[`CTRL_STOP_BIT] &&
                     wb_dat_i[`CTRL_TIMERS_OFF_BIT] && (link.mode == MODE_RUN);
    end
  end

  assign events = {refused, link.reset_done, link.fell_back, link.woke};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_ff <= '0;
      mask_ff <= '0;
    end else if (ce_i) begin
      if (wr && wb_adr_i == `REG_IRQ_MASK) begin
        mask_ff <= wb_dat_i[`EV_WIDTH-1:0];
      end
      if (wr && wb_adr_i == `REG_IRQ_STAT) begin
        stat_ff <= (stat_ff & ~wb_dat_i[`EV_WIDTH-1:0]) | events;
      end else begin
        stat_ff <= stat_ff | events;
      end
    end
  end

  assign irq_o = |(stat_ff & mask_ff);

  assign link.stop_req                    = stop_req_ff;
  assign link.serial_snooze_enable        = ctrl_ff[`CTRL_SERIAL_SNZ_BIT];
  assign link.adc_snooze_enable           = ctrl_ff[`CTRL_ADC_SNZ_BIT];
  assign link.vector_enable               = ctrl_ff[`CTRL_VECTOR_BIT];
  assign link.timers_stopped              = ctrl_ff[`CTRL_TIMERS_OFF_BIT];
  assign link.cmp_filter_used             = ctrl_ff[`CTRL_CMP_FILTER_BIT];
  assign link.oscillator_frequency_select = cfg_ff[`CFG_FREQ_SEL_BIT];
  assign link.wakeup_timer_clock_select   = cfg_ff[`CFG_WUT_CLK_BIT];
  assign link.speed_mode_control          = cfg_ff[`CFG_HS_MODE_BIT];
  assign link.watchdog_enable_option      = cfg_ff[`CFG_WDT_ON_BIT];
  assign link.watchdog_standby_run_option = cfg_ff[`CFG_WDT_STBY_BIT];
  assign link.cpu_on_fast_osc             = cfg_ff[`CFG_CPU_FAST_OSC_BIT];
endmodule

// File: standby_properties.sv
`timescale 1ns/1ns
module standby_properties (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               stop_req,
  input  wire logic               serial_snooze_enable,
  input  wire logic               adc_snooze_enable,
  input  wire logic               oscillator_frequency_select,
  input  wire logic               speed_mode_control,
  input  wire logic               cpu_on_fast_osc,
  input  wire logic               vector_enable,
  input  wire logic               timers_stopped,
  input  wire standby_pkg::mode_t mode,
  input  wire logic               woke,
  input  wire logic               fell_back,
  input  wire logic               reset_done
);
  import standby_pkg::*;
  // cycles spent in the previous mode, valid in the first cycle of a new one
  logic [11:0] cnt_ff;
  mode_t       mode_q_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q_ff <= MODE_RESET;
      cnt_ff    <= 12'h000;
    end else begin
      mode_q_ff <= mode;
      if (mode != mode_q_ff) cnt_ff <= 12'h001;
      else if (cnt_ff != 12'hFFF) cnt_ff <= cnt_ff + 12'h001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  stop_gate_a: assert property (stop_req |-> mode == MODE_RUN && timers_stopped)
    else $error("stop request outside run or with timers live");
  stop_entry_a: assert property (stop_req |=> mode == MODE_STOP)
    else $error("stop request did not enter stop");
  snooze_wait_a: assert property ((mode == MODE_SNOOZE && mode_q_ff == MODE_TO_SNOOZE) |->
    cnt_ff >= 12'h168 && cnt_ff <= (oscillator_frequency_select ? 12'hA8D : 12'h515))
    else $error("stop to snooze wait out of range");
  wake_vec_a: assert property ((mode == MODE_RUN && mode_q_ff == MODE_TO_NORMAL && vector_enable)
    |-> cnt_ff >= (speed_mode_control ? 12'h06B : 12'h01D)
     && cnt_ff <= (speed_mode_control ? 12'h0C5 : 12'h06E))
    else $error("vectored wake time out of range");
  wake_plain_a: assert property ((mode == MODE_RUN && mode_q_ff == MODE_TO_NORMAL && !vector_enable)
    |-> cnt_ff >= (speed_mode_control ? 12'h065 : 12'h017)
     && cnt_ff <= (speed_mode_control ? 12'h0BF : 12'h068))
    else $error("plain wake time out of range");
  woke_pulse_a: assert property ((mode == MODE_RUN && mode_q_ff == MODE_TO_NORMAL) |-> ##[0:1] woke)
    else $error("wake without woke pulse");
  fall_back_a: assert property ((mode == MODE_STOP && mode_q_ff == MODE_SNOOZE) |-> ##[0:1] fell_back)
    else $error("fallback without pulse");
  reset_exit_a: assert property ((mode == MODE_RUN && mode_q_ff == MODE_RESET) |-> ##[0:1] reset_done)
    else $error("reset exit without done pulse");
  normal_order_a: assert property ((mode == MODE_TO_NORMAL && mode_q_ff != MODE_TO_NORMAL)
    |-> mode_q_ff == MODE_SNOOZE) else $error("wake from wrong mode");
  snooze_order_a: assert property ((mode == MODE_SNOOZE && mode_q_ff != MODE_SNOOZE)
    |-> mode_q_ff == MODE_TO_SNOOZE) else $error("snooze from wrong mode");
  enable_clear_a: assert property (woke |-> ##[0:2] (!serial_snooze_enable && !adc_snooze_enable))
    else $error("snooze enables not cleared after wake");
  fast_osc_only_a: assert property ((serial_snooze_enable || adc_snooze_enable)
    |-> cpu_on_fast_osc)
    else $error("snooze enabled off the fast internal clock");

  cover property (mode == MODE_SNOOZE && mode_q_ff == MODE_TO_SNOOZE);
  cover property (woke);
  cover property (fell_back);
  cover property (reset_done);
endmodule

// File: tb.sv
`timescale 1ns/1ns
`include "standby_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;
  import standby_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [5:0]  src = 6'h00;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic [10:0] gates;
  logic [2:0]  anas;
  logic [15:0] fetch_addr_o;
  logic        fetch_o;
  mode_t       mode_o;
  int          n_errors = 0;
  int          comparisons = 0;
  int          fetch_cnt = 0;
  standby_if link_if ();
  standby_device u_standby_device (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link_if.dev),
    .reset_source_i(src[5]), .serial_activity_i(src[0]), .adc_trigger_i(src[1]),
    .serial_irq_i(src[2]), .adc_irq_i(src[3]), .periph_idle_i(src[4]),
    .cpu_clk_en_o(gates[10]), .cpu_ram_run_o(gates[9]), .fast_osc_run_o(gates[8]),
    .crystal_run_o(gates[7]), .ext_clk_accept_o(gates[6]), .port_hold_o(gates[5]),
    .serial_other_en_o(gates[4]), .serial_snz_ch_en_o(gates[3]), .aux_periph_en_o(gates[2]),
    .event_linker_en_o(gates[1]), .safety_run_o(gates[0]), .adc_en_o(anas[2]),
    .cmp_en_o(anas[1]), .slow_osc_run_o(anas[0]), .fetch_o(fetch_o),
    .fetch_addr_o(fetch_addr_o), .mode_o(mode_o));
  standby_controller u_standby_controller (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link_if.ctl), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
  standby_properties u_standby_properties (
    .clk_i(clk_i), .rst_i(rst_i), .stop_req(link_if.stop_req),
    .serial_snooze_enable(link_if.serial_snooze_enable),
    .adc_snooze_enable(link_if.adc_snooze_enable),
    .oscillator_frequency_select(link_if.oscillator_frequency_select),
    .speed_mode_control(link_if.speed_mode_control), .cpu_on_fast_osc(link_if.cpu_on_fast_osc),
    .vector_enable(link_if.vector_enable), .timers_stopped(link_if.timers_stopped),
    .mode(link_if.mode), .woke(link_if.woke), .fell_back(link_if.fell_back),
    .reset_done(link_if.reset_done));

  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (fetch_o === 1'b1) fetch_cnt++;

  task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      n_errors++;
      $display("ERROR t=%0t wb ack got=%0h exp=%0h", $time, wb_ack_o, 1'b1);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] adr, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, adr, 32'h0, q);
    `CHK(q & m, e)
  endtask
  task automatic wait_mode(input mode_t m, input int lim, output int n);
    n = 0;
    while (mode_o !== m && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= lim) begin
      n_errors++;
      $display("ERROR t=%0t mode wait got=%0h exp=%0h", $time, mode_o, m);
    end
  endtask
  // one-cycle pulse on a device input, bit order as in src
  task automatic pulse(input int which);
    @(posedge clk_i);
    src[which] <= 1'b1;
    @(posedge clk_i);
    src <= 6'h00;
  endtask

  task automatic t_regs;
    rd_chk(`REG_CONFIG, 32'hFF, 32'h24);
    rd_chk(`REG_IRQ_STAT, 32'hF, 32'h4);
    `CHK(fetch_cnt, 1)
    `CHK(fetch_addr_o, 16'h0000)
    `CHK(gates, 11'h7DF)
    wr(5'h14, 32'hFF);
    rd_chk(5'h14, 32'hFFFFFFFF, 32'h0);
    wr(`REG_IRQ_MASK, 32'h8);
    wr(`REG_IRQ_STAT, 32'hF);
    wr(`REG_CONFIG, 32'h04);
    wr(`REG_CTRL, 32'h12);
    rd_chk(`REG_CTRL, 32'h6, 32'h0);
    rd_chk(`REG_IRQ_STAT, 32'hF, 32'h8);
    @(negedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(`REG_IRQ_STAT, 32'h8);
    @(negedge clk_i);
    `CHK(irq_o, 1'b0)
    wr(`REG_CONFIG, 32'h24);
    wr(`REG_CTRL, 32'h01);
    repeat (4) @(negedge clk_i);
    `CHK(mode_o, MODE_RUN)
    wr(`REG_CTRL, 32'h0);
    wr(`REG_IRQ_MASK, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_wake(input logic [31:0] cfg, input logic [31:0] pre, input bit hs,
                        input bit vec, input bit freq);
    int n;
    int extra;
    extra = vec ? 7 : 1;
    wr(`REG_CONFIG, cfg);
    wr(`REG_IRQ_STAT, 32'hF);
    wr(`REG_CTRL, pre);
    wr(`REG_CTRL, pre | 32'h1);
    wait_mode(MODE_STOP, 10, n);
    `CHK(gates, 11'h02E)
    pulse(0);
    wait_mode(MODE_SNOOZE, 3000, n);
    `CHK(n >= 360 && n <= (freq ? 2703 : 1303), 1'b1)
    `CHK(gates, 11'h12E)
    `CHK(anas, 3'h6)
    pulse(2);
    wait_mode(MODE_RUN, 300, n);
    `CHK(n >= (hs ? 100 : 22) + extra && n <= (hs ? 189 : 102) + extra + 3, 1'b1)
    rd_chk(`REG_IRQ_STAT, 32'hF, 32'h1);
    rd_chk(`REG_CTRL, 32'h6, 32'h0);
    rd_chk(`REG_STATUS, 32'h7, 32'h0);
    $display("test wake done");
  endtask

  task automatic t_fallback;
    int n;
    wr(`REG_CONFIG, 32'h38);
    wr(`REG_IRQ_STAT, 32'hF);
    wr(`REG_CTRL, 32'h34);
    wr(`REG_CTRL, 32'h35);
    wait_mode(MODE_STOP, 10, n);
    pulse(1);
    wait_mode(MODE_SNOOZE, 1400, n);
    `CHK(n >= 360 && n <= 1303, 1'b1)
    `CHK(gates, 11'h126)
    `CHK(anas, 3'h5)
    pulse(4);
    wait_mode(MODE_STOP, 10, n);
    rd_chk(`REG_IRQ_STAT, 32'hF, 32'h2);
    // serial channel was not armed, so its activity must not start snooze
    pulse(0);
    repeat (5) @(negedge clk_i);
    `CHK(mode_o, MODE_STOP)
    pulse(5);
    wait_mode(MODE_RUN, 10, n);
    repeat (2) @(negedge clk_i);
    `CHK(fetch_cnt, 2)
    rd_chk(`REG_IRQ_STAT, 32'h4, 32'h4);
    rd_chk(`REG_CTRL, 32'h6, 32'h0);
    $display("test fallback done");
  endtask

  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    t_regs();
    t_wake(32'h2C, 32'h1A, 1'b1, 1'b1, 1'b0);
    t_wake(32'h29, 32'h12, 1'b0, 1'b0, 1'b1);
    t_fallback();
    print_verdict();
  end
  // the whole run needs about 5600 cycles
  initial begin
    #1000000;
    $display("watchdog expired");
    n_errors++;
    print_verdict();
  end
endmodule
